// ===== i2tp_map.svh
// Constants of the two-wire target register port
`ifndef I2TP_MAP_SVH
`define I2TP_MAP_SVH
// =============================================
// Address and framing
`define I2TP_ADDR_UPPER      4'hB
`define I2TP_BYTE_BITS       4'h8
`define I2TP_ACK_BIT         4'h8
// =============================================
// Timing
`define I2TP_CLK_PERIOD_NS   10
`define I2TP_SPIKE_NS        50
`define I2TP_FILT_CYC        (((`I2TP_SPIKE_NS) + (`I2TP_CLK_PERIOD_NS) - 1) / (`I2TP_CLK_PERIOD_NS))
`define I2TP_FILT_W          3
// =============================================
// FIFO
`define I2TP_FIFO_DEPTH      8
`define I2TP_FIFO_WIDTH      24
// =============================================
// Reset values
`define I2TP_RST_REG_ADDR    16'h0000
// Both select pins high: port off, also the strap value held in reset
`define I2TP_SEL_OFF         4'hA
`endif

// ===== i2tp_pkg.sv
// Types of the two-wire target register port
package i2tp_pkg;
	// =============================================
	// Protocol states
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_ADDR  = 3'b001,
		ST_ADDR_ACK = 3'b010,
		ST_WRX   = 3'b011,
		ST_WACK  = 3'b100,
		ST_RTX   = 3'b101,
		ST_RACK  = 3'b110,
		ST_WAIT  = 3'b111
	} i2tp_state_e;

	// Register write carried through the FIFO
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  data;
	} i2tp_wr_s;
endpackage

// ===== i2tp_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module i2tp_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             resetn,
	// Fill side
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	// Drain side
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;
	logic [AW:0]      fill;

	// =============================================
	// Pointers; full and empty from the count
	assign fill      = wr_ptr - rd_ptr;
	assign in_ready  = (fill != DEPTH[AW:0]);
	assign out_valid = (fill != '0);
	assign out_data  = mem[rd_ptr[AW-1:0]];

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (in_valid && in_ready) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (out_valid && out_ready) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end

	// Storage carries no reset
	always_ff @(posedge core_clk) begin
		if (in_valid && in_ready) begin
			mem[wr_ptr[AW-1:0]] <= in_data;
		end
	end
endmodule // i2tp_fifo

// ===== i2tp_target.sv
// Two-wire target port giving a bus master access to byte registers
`timescale 1ns/10ps
`include "i2tp_map.svh"

// Functional notes
// - SDA changes only while SCL is low, except start and stop.
// - SDA falling while SCL high is start; device detects it.
// - SDA rising while SCL high is stop; device detects it.
// - Bytes are eight bits, MSB first, then one acknowledge slot.
// - Receiver acknowledges by pulling SDA low on ninth pulse.
// - Receiver refuses a byte by leaving SDA high on ninth pulse.
// - First byte: seven-bit address MSB first, then direction, 0 write.
// - Acknowledge only own address; otherwise idle until next start.
// - Every start re-arms the receive logic.
// - Any number of data bytes per transfer.
// - Two bytes after address form register address, high first.
// - Later write bytes are stored from that register address.
// - Address-only write sets current address, changes no data.
// - Read drives data right after address byte from current address.
// - Combined read: address write, repeated start, read transfer.
// - Master refuses last read byte; device releases SDA.
// - Repeated start ends a transfer and begins a new one.
// - Start or stop anywhere; partial bytes discarded.
// - SCL and SDA are filtered against short spikes.
// - Upper four address bits are 1011.
// - Lower three bits from select pins; both high disables port.
// - Works at standard and fast mode clock rates.
module i2tp_target (
	// Clock and reset
	input  wire logic                core_clk,
	input  wire logic                resetn,
	// Bus pins
	input  wire logic                scl_in,
	input  wire logic                sda_in,
	output logic                     sda_out,
	output logic                     sda_oe,
	// Address select, decoded three-level pins: 00 low, 01 open, 10 high
	input  wire logic [1:0]          port_select_upper_pin,
	input  wire logic [1:0]          port_select_lower_pin,
	// Register write stream
	output i2tp_pkg::i2tp_wr_s       wr,
	output logic                     wr_valid,
	input  wire logic                wr_ready,
	// Register read
	output logic [15:0]              rd_addr,
	input  wire logic [7:0]          rd_data,
	// Status
	output logic                     port_enabled
);
	// =============================================
	// State
	typedef struct packed {
		logic [1:0]              scl_sy;
		logic [1:0]              sda_sy;
		logic [`I2TP_FILT_W-1:0] scl_cnt;
		logic [`I2TP_FILT_W-1:0] sda_cnt;
		logic                    scl_f;
		logic                    sda_f;
		i2tp_pkg::i2tp_state_e   st;
		logic [3:0]              bit_cnt;
		logic [7:0]              shreg;
		logic [1:0]              addr_bytes;
		logic                    rnw;
		logic [15:0]             reg_addr;
		logic                    sda_oe;
		logic                    sda_out;
		logic                    push;
		i2tp_pkg::i2tp_wr_s      push_data;
		logic                    en;
		logic [6:0]              own_addr;
		logic [3:0]              sel_sy0;
		logic [3:0]              sel_sy1;
	} i2tp_st_s;

	i2tp_st_s          r;
	i2tp_st_s          next_r;
	logic              fifo_in_ready;
	logic              scl_rise;
	logic              scl_fall;
	logic              start_cond;
	logic              stop_cond;
	logic [2:0]        sel_code;

	// =============================================
	// Select straps come from pins, so only their second flop is decoded
	// Three-level pair to 0..7; both high would give 8, which wraps to 0 in three bits
	assign sel_code   = 3'(r.sel_sy1[3:2] * 2'd3 + r.sel_sy1[1:0]);

	always_comb begin
		next_r      = r;
		next_r.push = 1'b0;
		// Two flops before any logic reads the pins
		next_r.scl_sy = {r.scl_sy[0], scl_in};
		next_r.sda_sy = {r.sda_sy[0], sda_in};
		// Spike filter: level must persist before it is accepted
		if (r.scl_sy[1] == r.scl_f) begin
			next_r.scl_cnt = '0;
		end else if (r.scl_cnt == `I2TP_FILT_W'(`I2TP_FILT_CYC)) begin
			next_r.scl_f   = r.scl_sy[1];
			next_r.scl_cnt = '0;
		end else begin
			next_r.scl_cnt = r.scl_cnt + 1'b1;
		end
		if (r.sda_sy[1] == r.sda_f) begin
			next_r.sda_cnt = '0;
		end else if (r.sda_cnt == `I2TP_FILT_W'(`I2TP_FILT_CYC)) begin
			next_r.sda_f   = r.sda_sy[1];
			next_r.sda_cnt = '0;
		end else begin
			next_r.sda_cnt = r.sda_cnt + 1'b1;
		end
		// Edges and bus conditions; made here so nothing loops back through next_r
		scl_rise   = !r.scl_f && next_r.scl_f;
		scl_fall   = r.scl_f && !next_r.scl_f;
		start_cond = r.scl_f && next_r.scl_f && r.sda_f && !next_r.sda_f;
		stop_cond  = r.scl_f && next_r.scl_f && !r.sda_f && next_r.sda_f;
		// Straps follow the synchronised select pins; both high disables the port
		next_r.sel_sy0  = {port_select_upper_pin, port_select_lower_pin};
		next_r.sel_sy1  = r.sel_sy0;
		next_r.en       = (r.sel_sy1 != `I2TP_SEL_OFF);
		next_r.own_addr = {`I2TP_ADDR_UPPER, sel_code};

		// Protocol engine, run on filtered SCL edges
		if (!r.en) begin
			next_r.st     = i2tp_pkg::ST_IDLE;
			next_r.sda_oe = 1'b0;
		end else if (start_cond) begin
			// Any start, repeated or not, re-arms and drops partial bytes
			next_r.st      = i2tp_pkg::ST_ADDR;
			next_r.bit_cnt = '0;
			next_r.sda_oe  = 1'b0;
		end else if (stop_cond) begin
			next_r.st     = i2tp_pkg::ST_IDLE;
			next_r.sda_oe = 1'b0;
		end else begin
			case (r.st)
				i2tp_pkg::ST_ADDR, i2tp_pkg::ST_WRX: begin
					if (scl_rise) begin
						next_r.shreg   = {r.shreg[6:0], next_r.sda_f};
						next_r.bit_cnt = r.bit_cnt + 1'b1;
					end
					if (scl_fall && r.bit_cnt == `I2TP_BYTE_BITS) begin
						next_r.bit_cnt = '0;
						if (r.st == i2tp_pkg::ST_ADDR) begin
							if (r.shreg[7:1] == r.own_addr) begin
								next_r.rnw    = r.shreg[0];
								next_r.sda_oe = 1'b1;
								next_r.sda_out = 1'b0;
								next_r.addr_bytes = '0;
								next_r.st     = i2tp_pkg::ST_ADDR_ACK;
							end else begin
								next_r.st = i2tp_pkg::ST_IDLE;
							end
						end else if (r.addr_bytes != 2'd2) begin
							// Register address, high byte first
							if (r.addr_bytes == 2'd0) begin
								next_r.reg_addr[15:8] = r.shreg;
							end else begin
								next_r.reg_addr[7:0] = r.shreg;
							end
							next_r.addr_bytes = r.addr_bytes + 1'b1;
							next_r.sda_oe = 1'b1;
							next_r.sda_out = 1'b0;
							next_r.st     = i2tp_pkg::ST_WACK;
						end else if (fifo_in_ready) begin
							next_r.push      = 1'b1;
							next_r.push_data = '{addr: r.reg_addr, data: r.shreg};
							next_r.reg_addr  = r.reg_addr + 1'b1;
							next_r.sda_oe    = 1'b1;
							next_r.sda_out   = 1'b0;
							next_r.st        = i2tp_pkg::ST_WACK;
						end else begin
							// No room: refuse the byte by leaving SDA released
							next_r.sda_oe = 1'b0;
							next_r.st     = i2tp_pkg::ST_WACK;
						end
					end
				end
				i2tp_pkg::ST_ADDR_ACK, i2tp_pkg::ST_WACK: begin
					if (scl_fall) begin
						if (r.st == i2tp_pkg::ST_ADDR_ACK && r.rnw) begin
							// Read begins right after the address byte
							next_r.shreg   = rd_data;
							next_r.sda_out = rd_data[7];
							next_r.sda_oe  = 1'b1;
							next_r.bit_cnt = 4'h1;
							next_r.st      = i2tp_pkg::ST_RTX;
						end else begin
							next_r.sda_oe = 1'b0;
							next_r.st     = i2tp_pkg::ST_WRX;
						end
					end
				end
				i2tp_pkg::ST_RTX: begin
					if (scl_fall) begin
						if (r.bit_cnt == `I2TP_BYTE_BITS) begin
							next_r.sda_oe = 1'b0; // Master drives acknowledge
							next_r.reg_addr = r.reg_addr + 1'b1;
							next_r.st     = i2tp_pkg::ST_RACK;
						end else begin
							next_r.sda_out = r.shreg[3'(7 - r.bit_cnt)];
							next_r.bit_cnt = r.bit_cnt + 1'b1;
						end
					end
				end
				i2tp_pkg::ST_RACK: begin
					if (scl_rise) begin
						// Refusal ends the read and leaves SDA released
						next_r.st = next_r.sda_f ? i2tp_pkg::ST_WAIT : i2tp_pkg::ST_RACK;
						next_r.rnw = !next_r.sda_f;
					end
					if (scl_fall && r.rnw) begin
						next_r.shreg   = rd_data;
						next_r.sda_out = rd_data[7];
						next_r.sda_oe  = 1'b1;
						next_r.bit_cnt = 4'h1;
						next_r.st      = i2tp_pkg::ST_RTX;
					end
				end
				i2tp_pkg::ST_WAIT, i2tp_pkg::ST_IDLE: begin
					next_r.sda_oe = 1'b0;
				end
				default: begin
					next_r.st = i2tp_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			// Straps start at the off code so the port stays quiet until the pins are seen
			r <= '{scl_sy: 2'h3, sda_sy: 2'h3, scl_f: 1'b1, sda_f: 1'b1, st: i2tp_pkg::ST_IDLE,
				reg_addr: `I2TP_RST_REG_ADDR, sda_out: 1'b1, sel_sy0: `I2TP_SEL_OFF,
				sel_sy1: `I2TP_SEL_OFF, default: '0};
		end else begin
			r <= next_r;
		end
	end

	// =============================================
	// Write FIFO; when full, incoming bytes are refused on the bus
	i2tp_fifo #(
		.WIDTH (`I2TP_FIFO_WIDTH),
		.DEPTH (`I2TP_FIFO_DEPTH)
	) u_fifo (
		.core_clk  (core_clk),
		.resetn    (resetn),
		.in_data   (r.push_data),
		.in_valid  (r.push),
		.in_ready  (fifo_in_ready),
		.out_data  (wr),
		.out_valid (wr_valid),
		.out_ready (wr_ready)
	);

	assign sda_out      = r.sda_out;
	assign sda_oe       = r.sda_oe;
	assign rd_addr      = r.reg_addr;
	assign port_enabled = r.en;

	// =============================================
	// Checks
	AST_ACK_LOW: assert property (@(posedge core_clk) disable iff (!resetn)
		(r.st == i2tp_pkg::ST_ADDR_ACK) |-> (sda_oe && !sda_out))
		else $error("ack slot not driven low");
	AST_START_REARM: assert property (@(posedge core_clk) disable iff (!resetn)
		(r.en && start_cond) |=> (r.st == i2tp_pkg::ST_ADDR && r.bit_cnt == 4'h0))
		else $error("start did not re-arm");
	AST_STOP_IDLE: assert property (@(posedge core_clk) disable iff (!resetn)
		(r.en && stop_cond && !start_cond) |=> (r.st == i2tp_pkg::ST_IDLE && !sda_oe))
		else $error("stop did not idle");
	AST_DISABLED: assert property (@(posedge core_clk) disable iff (!resetn)
		!r.en |=> !sda_oe)
		else $error("disabled port drives sda");
	AST_PUSH_INC: assert property (@(posedge core_clk) disable iff (!resetn)
		r.push |-> (r.reg_addr == r.push_data.addr + 16'h0001))
		else $error("address not advanced");
	AST_NO_DRIVE_IDLE: assert property (@(posedge core_clk) disable iff (!resetn)
		(r.st == i2tp_pkg::ST_IDLE) |=> !sda_oe)
		else $error("idle target drives sda");
	AST_RX_HOLD: assert property (@(posedge core_clk) disable iff (!resetn)
		(sda_oe && r.scl_f && next_r.scl_f && !start_cond && !stop_cond) |=> $stable(sda_out))
		else $error("sda changed during scl high");
	AST_NACK_RELEASE: assert property (@(posedge core_clk) disable iff (!resetn)
		(r.st == i2tp_pkg::ST_RACK && scl_rise && next_r.sda_f) |=> ##1 !sda_oe)
		else $error("sda held after refusal");
	AST_MISMATCH_IDLE: assert property (@(posedge core_clk) disable iff (!resetn)
		(r.en && r.st == i2tp_pkg::ST_ADDR && scl_fall && r.bit_cnt == 4'h8 && r.shreg[7:1] != r.own_addr)
		|=> (r.st == i2tp_pkg::ST_IDLE && !sda_oe))
		else $error("foreign address answered");
	AST_READ_LOAD: assert property (@(posedge core_clk) disable iff (!resetn)
		(r.en && r.st == i2tp_pkg::ST_ADDR_ACK && r.rnw && scl_fall)
		|=> (r.st == i2tp_pkg::ST_RTX && sda_oe && sda_out == $past(rd_data[7])))
		else $error("read byte not loaded from register");
	AST_FULL_NACK: assert property (@(posedge core_clk) disable iff (!resetn)
		(r.en && r.st == i2tp_pkg::ST_WRX && scl_fall && r.bit_cnt == 4'h8 && r.addr_bytes == 2'd2 && !fifo_in_ready)
		|=> (!sda_oe && !r.push))
		else $error("byte acknowledged with no room");
	AST_ADDR_LOW: assert property (@(posedge core_clk) disable iff (!resetn)
		(r.en && r.st == i2tp_pkg::ST_WRX && scl_fall && r.bit_cnt == 4'h8 && r.addr_bytes == 2'd1)
		|=> (rd_addr[7:0] == $past(r.shreg) && !r.push))
		else $error("low address byte not taken");
endmodule // i2tp_target

// ===== i2tp_master_model.sv
// Behavioural bus master that drives the two-wire port from the far side
`timescale 1ns/10ps
module i2tp_master_model (
	// Pacing clock
	input  wire logic core_clk,
	// Bus lines
	input  wire logic sda,
	output logic      scl,
	output logic      sda_low
);
	// =============================================
	// Bus primitives
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// Quarter bit; SCL stands still between frames
	task automatic tick;
		repeat (40) @(posedge core_clk);
		#1;
	endtask
	// Start or repeated start
	task automatic start;
		sda_low = 1'b0;
		tick;
		scl = 1'b1;
		tick;
		sda_low = 1'b1;
		tick;
		scl = 1'b0;
		tick;
	endtask
	// Stop
	task automatic stop;
		sda_low = 1'b1;
		tick;
		scl = 1'b1;
		tick;
		sda_low = 1'b0;
		tick;
	endtask
	// Short SCL pulse that the input filter must swallow
	task automatic spike;
		scl = 1'b1;
		repeat (2) @(posedge core_clk);
		#1 scl = 1'b0;
	endtask
	// One bit: SDA set while SCL low, one pulse, sampled mid-high
	task automatic bit_io(input logic b, output logic r);
		sda_low = ~b;
		tick;
		scl = 1'b1;
		tick;
		r = sda;
		tick;
		scl = 1'b0;
		tick;
	endtask
	// Byte out MSB first, then the acknowledge slot
	task automatic put_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, r);
		ack = ~r;
	endtask
	// Byte in, then acknowledge or refuse it
	task automatic get_byte(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, d[i]);
		end
		bit_io(~ack, r);
	endtask
endmodule // i2tp_master_model

// ===== i2c_target_register_port_test.sv
// Self-checking bench for the two-wire target register port
`timescale 1ns/10ps
module i2c_target_register_port_test;
	// =============================================
	// Signals and model state
	logic               core_clk = 1'b0;
	logic               resetn = 1'b0;
	logic               scl;
	logic               m_low;
	wire                sda;
	logic               dut_sda_out;
	logic               dut_sda_oe;
	logic [1:0]         sel_hi = 2'h2;
	logic [1:0]         sel_lo = 2'h2;
	i2tp_pkg::i2tp_wr_s wr;
	logic               wr_valid;
	logic               wr_ready = 1'b1;
	logic               hold = 1'b0;
	logic [15:0]        rd_addr;
	logic [7:0]         rd_data;
	logic               port_enabled;
	logic [7:0]         mem [65536];
	logic [7:0]         exp_mem [65536];
	logic [23:0]        exp_q [$];
	int                 cur;
	int                 bad_count = 0;
	int                 num_checks = 0;
	logic               ack;
	logic [7:0]         d;
	logic [6:0]         own;

	// Pull-up wins unless a party pulls low
	assign sda = ~(m_low | (dut_sda_oe & ~dut_sda_out));
	always #5 core_clk = ~core_clk;
	always_comb rd_data = mem[rd_addr];

	i2tp_master_model i_mst (.core_clk(core_clk), .sda(sda), .scl(scl), .sda_low(m_low));
	i2tp_target i_dut (
		.core_clk(core_clk), .resetn(resetn), .scl_in(scl), .sda_in(sda),
		.sda_out(dut_sda_out), .sda_oe(dut_sda_oe),
		.port_select_upper_pin(sel_hi), .port_select_lower_pin(sel_lo),
		.wr(wr), .wr_valid(wr_valid), .wr_ready(wr_ready),
		.rd_addr(rd_addr), .rd_data(rd_data), .port_enabled(port_enabled)
	);

	// =============================================
	// Compare and report
	task automatic cmp(input logic [23:0] g, input logic [23:0] e);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value at %0t: got %0h expected %0h", $time, g, e);
		end
	endtask
	task automatic chk_ack(input logic g, input logic e);
		cmp({23'h0, g}, {23'h0, e});
	endtask
	task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
		cmp({16'h0, g}, {16'h0, e});
	endtask
	task automatic chk_wr(input logic [23:0] g, input logic [23:0] e);
		cmp(g, e);
	endtask
	task automatic chk_addr(input logic [15:0] g, input logic [15:0] e);
		cmp({8'h0, g}, {8'h0, e});
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Register file behind the write stream; random stalls exercise the FIFO
	always @(posedge core_clk) begin
		if (wr_valid && wr_ready) begin
			mem[wr.addr] = wr.data;
			chk_wr(wr, exp_q.size() != 0 ? exp_q.pop_front() : 24'hXXXXXX);
		end
		#1 wr_ready = ~hold & ($urandom_range(0, 3) != 0);
	end

	// =============================================
	// Transfer helpers
	task automatic set_addr(input logic [15:0] a);
		i_mst.start;
		i_mst.put_byte({own, 1'b0}, ack);
		chk_ack(ack, 1'b1);
		i_mst.put_byte(a[15:8], ack);
		chk_ack(ack, 1'b1);
		i_mst.put_byte(a[7:0], ack);
		chk_ack(ack, 1'b1);
		cur = a;
	endtask
	// Acknowledged only while the FIFO has room
	task automatic put_data(input int n, input int room);
		for (int i = 0; i < n; i++) begin
			d = 8'($urandom);
			// Queued first: the word may leave the FIFO before the acknowledge slot ends
			if (i < room) begin
				exp_q.push_back({cur[15:0], d});
				exp_mem[cur] = d;
				cur = (cur + 1) & 32'hFFFF;
			end
			i_mst.put_byte(d, ack);
			chk_ack(ack, i < room);
		end
	endtask
	task automatic rd_head;
		i_mst.start;
		i_mst.put_byte({own, 1'b1}, ack);
		chk_ack(ack, 1'b1);
	endtask
	task automatic get_data(input int n);
		for (int i = 0; i < n; i++) begin
			i_mst.get_byte(i < n - 1, d);
			chk_byte(d, exp_mem[cur]);
			cur = (cur + 1) & 32'hFFFF;
		end
	endtask
	task automatic drain;
		int n;
		n = 0;
		while (exp_q.size() != 0 && n < 3000) begin
			@(posedge core_clk);
			n++;
		end
		if (exp_q.size() != 0) begin
			bad_count++;
			stop_test;
		end
	endtask

	// Hang guard
	initial begin
		repeat (100000) @(posedge core_clk);
		bad_count++;
		stop_test;
	end

	// =============================================
	// Main sequence
	initial begin
		void'($urandom(41));
		for (int i = 0; i < 65536; i++) begin
			mem[i] = 8'(i) ^ 8'(i >> 8);
			exp_mem[i] = mem[i];
		end
		repeat (10) @(posedge core_clk);
		#1 resetn = 1'b1;
		repeat (5) @(posedge core_clk);
		chk_ack(port_enabled, 1'b0);
		i_mst.start;
		i_mst.put_byte(8'hB6, ack);
		chk_ack(ack, 1'b0);
		i_mst.stop;
		$display("test disabled port done");
		// Second reset with the port enabled; the stop above ends just after an edge
		resetn = 1'b0;
		sel_hi = 2'h0;
		sel_lo = 2'h0;
		repeat (10) @(posedge core_clk);
		#1 resetn = 1'b1;
		repeat (5) @(posedge core_clk);
		chk_ack(port_enabled, 1'b1);
		for (int k = 0; k < 8; k++) begin
			sel_hi = 2'(k / 3);
			sel_lo = 2'(k % 3);
			own = {4'hB, 3'(k)};
			repeat (3) @(posedge core_clk);
			i_mst.start;
			i_mst.put_byte({own ^ 7'h01, 1'b0}, ack);
			chk_ack(ack, 1'b0);
			i_mst.start;
			i_mst.put_byte({own, 1'b0}, ack);
			chk_ack(ack, 1'b1);
			i_mst.stop;
		end
		$display("test address select done");
		set_addr(16'h7FFE);
		i_mst.spike;
		put_data(6, 6);
		i_mst.stop;
		chk_addr(rd_addr, cur[15:0]);
		drain;
		$display("test stream write done");
		set_addr(16'h7FFD);
		i_mst.stop;
		chk_addr(rd_addr, 16'h7FFD);
		rd_head;
		get_data(3);
		i_mst.stop;
		chk_ack(dut_sda_oe, 1'b0);
		rd_head;
		get_data(2);
		i_mst.stop;
		$display("test current read done");
		hold = 1'b1;
		set_addr(16'h0100);
		put_data(9, 8);
		chk_addr(rd_addr, cur[15:0]);
		i_mst.stop;
		hold = 1'b0;
		drain;
		$display("test fifo full done");
		set_addr(16'h0200);
		put_data(1, 1);
		for (int i = 0; i < 4; i++) begin
			i_mst.bit_io(1'b0, ack);
		end
		drain;
		rd_head;
		get_data(1);
		i_mst.stop;
		drain;
		$display("test abort done");
		stop_test;
	end
endmodule // i2c_target_register_port_test
